// ---- design/qpd_pkg.sv ----
package qpd_pkg;
    // frame header layout
    localparam logic [3:0] TYPE_ID = 4'h9;   // arbitrary value, not a real maker code
    localparam int ID_TYPE_LSB = 4;
    localparam int OPC_LSB = 4;
    localparam int RSEL_LSB = 2;
    localparam int TAP_W = 6;
    localparam int NPOT = 4;
    localparam int NREG = 4;
    // opcodes
    localparam logic [3:0] OP_RD_WIPER = 4'h9;
    localparam logic [3:0] OP_WR_WIPER = 4'hA;
    localparam logic [3:0] OP_RD_SET = 4'hB;
    localparam logic [3:0] OP_WR_SET = 4'hC;
    localparam logic [3:0] OP_SET2WIP = 4'hD;
    localparam logic [3:0] OP_WIP2SET = 4'hE;
    localparam logic [3:0] OP_G_SET2WIP = 4'h1;
    localparam logic [3:0] OP_G_WIP2SET = 4'h8;
    localparam logic [3:0] OP_STEP = 4'h2;
    localparam logic [7:0] INSTR_STATUS = 8'h51;
    // timing
    localparam int CLK_MHZ = 50;
    localparam int NV_WRITE_MS = 10;
    localparam int NV_WRITE_CYC = NV_WRITE_MS * 1000 * CLK_MHZ;
    localparam int LOAD_DELAY_US = 10;
    localparam int LOAD_DELAY_CYC = LOAD_DELAY_US * CLK_MHZ;

    typedef struct packed {
        logic [3:0] opc;
        logic [1:0] rsel;
        logic [1:0] psel;
    } qpd_instr_t;
endpackage

// ---- design/qpd_decoder.sv ----
// Notes on behaviour
// - first byte after select fall is id; upper nibble must match type code
// - id low two bits must equal the two address straps
// - instruction: opcode nibble, register select pair, pot select pair
// - opcode values decode reads, writes, copies, global copies and stepping
// - copy instructions end after the instruction byte, no data byte
// - setting-to-wiper copy loads wiper after a bounded load delay
// - nonvolatile store starts at select rise after a full frame, busy for write time
// - global copies act on all four pots with the chosen register
// - read/write wiper, setting and status are three-byte frames
// - data byte: top two bits zero, six tap bits msb first
// - read wiper shifts out current tap of the selected pot
// - read setting shifts out the addressed setting register
// - write wiper loads the six bits into the selected wiper
// - write setting captures value, store starts at select rise
// - status instruction returns busy flag in bit zero, others zero
// - step: clock high with input high moves wiper up one
// - step: clock high with input low moves wiper down one
// - sample input on rising clock, drive output on falling, release when deselected
// - pause input low with clock low freezes the frame until released
// - after reset each wiper loads setting zero of its pot
// - write-protect low blocks nonvolatile writes
`timescale 1ns/1ps
`default_nettype none
module qpd_decoder #(
    parameter int NV_CYC = qpd_pkg::NV_WRITE_CYC,
    parameter int LOAD_CYC = qpd_pkg::LOAD_DELAY_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // serial pins
    input wire logic sck,
    input wire logic si,
    input wire logic cs_n,
    input wire logic hold_n,
    output logic so_o,
    output logic so_oe,
    // straps
    input wire logic addr_strap_0,
    input wire logic addr_strap_1,
    input wire logic wp_n,
    // tap outputs and write busy flag
    output logic [4*6-1:0] wiper_tap,
    output logic write_busy
);
    localparam int TW = qpd_pkg::TAP_W;
    localparam int ID_TYPE_L = qpd_pkg::ID_TYPE_LSB;

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic [2:0] sck_s, si_s, cs_s, hold_s, wp_s;
    logic sck_q, cs_q, hold_q, si_q, wp_q;
    // three stages; a change counts once stages two and three agree
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sck_s <= 3'h0;
            si_s <= 3'h0;
            cs_s <= 3'h7;
            hold_s <= 3'h7;
            wp_s <= 3'h7;
        end else begin
            sck_s <= {sck_s[1:0], sck};
            si_s <= {si_s[1:0], si};
            cs_s <= {cs_s[1:0], cs_n};
            hold_s <= {hold_s[1:0], hold_n};
            wp_s <= {wp_s[1:0], wp_n};
        end
    end
    // filtered levels
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sck_q <= 1'b0;
            cs_q <= 1'b1;
            hold_q <= 1'b1;
            wp_q <= 1'b1;
            si_q <= 1'b0;
        end else begin
            if (sck_s[1] == sck_s[2]) sck_q <= sck_s[2];
            if (cs_s[1] == cs_s[2]) cs_q <= cs_s[2];
            if (si_s[1] == si_s[2]) si_q <= si_s[2];
            if (wp_s[1] == wp_s[2]) wp_q <= wp_s[2];
            if ((hold_s[1] == hold_s[2]) && !sck_q) hold_q <= hold_s[2];
        end
    end
    logic new_sck, sck_rise, sck_fall, cs_fall, cs_rise;
    assign new_sck = (sck_s[1] == sck_s[2]) ? sck_s[2] : sck_q;
    assign sck_rise = new_sck && !sck_q && hold_q && !cs_q;
    assign sck_fall = !new_sck && sck_q && hold_q && !cs_q;
    assign cs_fall = (cs_s[1] == cs_s[2]) && !cs_s[2] && cs_q;
    assign cs_rise = (cs_s[1] == cs_s[2]) && cs_s[2] && !cs_q;

    // ----------------------------------------
    // frame state
    // ----------------------------------------
    typedef enum logic [2:0] {S_IDLE, S_ID, S_INS, S_DATA, S_STEP, S_DONE, S_IGN} qpd_st_t;
    qpd_st_t st_q;
    logic [2:0] bit_q;
    logic [7:0] sh_q;
    logic [7:0] rx_byte;
    qpd_pkg::qpd_instr_t ins_q;
    qpd_pkg::qpd_instr_t rx_ins;
    logic byte_end;
    assign rx_byte = {sh_q[6:0], si_q};
    assign rx_ins = rx_byte;
    assign byte_end = sck_rise && (bit_q == 3'd7);

    logic [TW-1:0] wiper_q [qpd_pkg::NPOT];
    logic [TW-1:0] nvreg_q [qpd_pkg::NPOT][qpd_pkg::NREG];
    logic busy_q;

    // three-byte opcodes and two-byte copies
    function automatic logic is_three(input logic [7:0] b);
        qpd_pkg::qpd_instr_t i;
        i = b;
        return (i.opc == qpd_pkg::OP_RD_WIPER) || (i.opc == qpd_pkg::OP_WR_WIPER)
            || (i.opc == qpd_pkg::OP_RD_SET) || (i.opc == qpd_pkg::OP_WR_SET)
            || (b == qpd_pkg::INSTR_STATUS);
    endfunction
    function automatic logic is_copy(input logic [3:0] o);
        return (o == qpd_pkg::OP_SET2WIP) || (o == qpd_pkg::OP_WIP2SET)
            || (o == qpd_pkg::OP_G_SET2WIP) || (o == qpd_pkg::OP_G_WIP2SET);
    endfunction

    // bit counter and shift register
    always_ff @(posedge sys_clk) begin
        if (sys_rst || cs_fall) begin
            bit_q <= 3'd0;
            sh_q <= 8'h00;
        end else if (sck_rise) begin
            bit_q <= bit_q + 3'd1;
            sh_q <= rx_byte;
        end
    end

    // frame sequencer
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_q <= S_IDLE;
            ins_q <= '0;
        end else if (cs_fall) begin
            st_q <= S_ID;
        end else if (cs_q) begin
            st_q <= S_IDLE;
        end else if (byte_end) begin
            unique case (st_q)
                S_ID: begin
                    if (rx_byte[7:ID_TYPE_L] == qpd_pkg::TYPE_ID
                        && rx_byte[1:0] == {addr_strap_1, addr_strap_0})
                        st_q <= S_INS;
                    else
                        st_q <= S_IGN;
                end
                S_INS: begin
                    ins_q <= rx_ins;
                    if (is_three(rx_byte)) st_q <= S_DATA;
                    else if (rx_ins.opc == qpd_pkg::OP_STEP) st_q <= S_STEP;
                    else if (is_copy(rx_ins.opc)) st_q <= S_DONE;
                    else st_q <= S_IGN;
                end
                S_DATA: st_q <= S_DONE;
                S_STEP: st_q <= S_STEP;
                S_DONE: st_q <= S_IGN; // extra bytes void the frame
                S_IGN: st_q <= S_IGN;
                S_IDLE: st_q <= S_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // serial output
    // ----------------------------------------
    logic [7:0] tx_q;
    logic [7:0] rd_val;
    always_comb begin
        rd_val = 8'h00;
        if (ins_q == qpd_pkg::INSTR_STATUS) rd_val = {7'h00, busy_q};
        else if (ins_q.opc == qpd_pkg::OP_RD_WIPER) rd_val = {2'b00, wiper_q[ins_q.psel]};
        else if (ins_q.opc == qpd_pkg::OP_RD_SET)
            rd_val = {2'b00, nvreg_q[ins_q.psel][ins_q.rsel]};
    end
    logic tx_en_q;
    // shifter loads at instruction end, shifts on falling edges
    always_ff @(posedge sys_clk) begin
        if (sys_rst || cs_q) begin
            tx_q <= 8'h00;
            tx_en_q <= 1'b0;
            so_o <= 1'b0;
        end else if (sck_fall && st_q == S_DATA && bit_q == 3'd0) begin
            tx_en_q <= 1'b1;
            so_o <= rd_val[7];
            tx_q <= {rd_val[6:0], 1'b0};
        end else if (sck_fall && tx_en_q && st_q == S_DATA) begin
            so_o <= tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end
    // released when deselected or paused; only reads drive
    assign so_oe = !cs_q && hold_q && tx_en_q && st_q == S_DATA
        && (ins_q.opc == qpd_pkg::OP_RD_WIPER || ins_q.opc == qpd_pkg::OP_RD_SET
        || ins_q == qpd_pkg::INSTR_STATUS);

    // ----------------------------------------
    // commit at select rise
    // ----------------------------------------
    logic [7:0] data_q;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) data_q <= 8'h00;
        else if (byte_end && st_q == S_DATA) data_q <= rx_byte;
    end
    logic done_ok;
    assign done_ok = cs_rise && st_q == S_DONE;
    logic nv_go;
    assign nv_go = done_ok && wp_q && !busy_q
        && (ins_q.opc == qpd_pkg::OP_WR_SET || ins_q.opc == qpd_pkg::OP_WIP2SET
        || ins_q.opc == qpd_pkg::OP_G_WIP2SET);

    // nonvolatile write timer
    logic [31:0] nv_cnt_q;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            busy_q <= 1'b0;
            nv_cnt_q <= 32'h0;
        end else if (nv_go) begin
            busy_q <= 1'b1;
            nv_cnt_q <= 32'(NV_CYC - 1);
        end else if (busy_q) begin
            if (nv_cnt_q == 32'h0) busy_q <= 1'b0;
            else nv_cnt_q <= nv_cnt_q - 32'h1;
        end
    end
    assign write_busy = busy_q;

    // pending store captured at select rise
    qpd_pkg::qpd_instr_t nv_ins_q;
    logic [TW-1:0] nv_val_q [qpd_pkg::NPOT];
    always_ff @(posedge sys_clk) begin
        if (sys_rst) nv_ins_q <= '0;
        else if (nv_go) begin
            nv_ins_q <= ins_q;
            for (int p = 0; p < qpd_pkg::NPOT; p++)
                nv_val_q[p] <= (ins_q.opc == qpd_pkg::OP_WR_SET) ? data_q[TW-1:0] : wiper_q[p];
        end
    end
    // setting array updates when the write cycle finishes
    always_ff @(posedge sys_clk) begin
        if (busy_q && nv_cnt_q == 32'h0) begin
            for (int p = 0; p < qpd_pkg::NPOT; p++)
                if (nv_ins_q.opc == qpd_pkg::OP_G_WIP2SET || p == int'(nv_ins_q.psel))
                    nvreg_q[p][nv_ins_q.rsel] <= nv_val_q[p];
        end
    end

    // ----------------------------------------
    // wiper registers
    // ----------------------------------------
    logic load_go, load_pend_q, init_q;
    logic [31:0] load_cnt_q;
    qpd_pkg::qpd_instr_t load_ins_q;
    assign load_go = done_ok
        && (ins_q.opc == qpd_pkg::OP_SET2WIP || ins_q.opc == qpd_pkg::OP_G_SET2WIP);
    // load delay timer
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            load_pend_q <= 1'b0;
            load_cnt_q <= 32'h0;
            load_ins_q <= '0;
        end else if (load_go) begin
            load_pend_q <= 1'b1;
            load_cnt_q <= 32'(LOAD_CYC - 1);
            load_ins_q <= ins_q;
        end else if (load_pend_q) begin
            if (load_cnt_q == 32'h0) load_pend_q <= 1'b0;
            else load_cnt_q <= load_cnt_q - 32'h1;
        end
    end
    logic step_ev;
    assign step_ev = sck_rise && st_q == S_STEP;
    // wiper update: init, copy, write, step
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            init_q <= 1'b1;
        end else begin
            init_q <= 1'b0;
            for (int p = 0; p < qpd_pkg::NPOT; p++) begin
                if (init_q) wiper_q[p] <= nvreg_q[p][0];
                else if (load_pend_q && load_cnt_q == 32'h0
                    && (load_ins_q.opc == qpd_pkg::OP_G_SET2WIP || p == int'(load_ins_q.psel)))
                    wiper_q[p] <= nvreg_q[p][load_ins_q.rsel];
                else if (done_ok && ins_q.opc == qpd_pkg::OP_WR_WIPER && p == int'(ins_q.psel))
                    wiper_q[p] <= data_q[TW-1:0];
                else if (step_ev && p == int'(ins_q.psel)) begin
                    if (si_q && wiper_q[p] != 6'h3F) wiper_q[p] <= wiper_q[p] + 6'h01;
                    else if (!si_q && wiper_q[p] != 6'h00) wiper_q[p] <= wiper_q[p] - 6'h01;
                end
            end
        end
    end
    for (genvar g = 0; g < qpd_pkg::NPOT; g++) begin : g_tap
        assign wiper_tap[g*TW +: TW] = wiper_q[g];
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_busy_start;
        @(posedge sys_clk) disable iff (sys_rst) nv_go |=> busy_q;
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy not set");
    property p_wp_block;
        @(posedge sys_clk) disable iff (sys_rst) !wp_q |-> !nv_go;
    endproperty
    a_wp_block: assert property (p_wp_block) else $error("store under protect");
    property p_short_frame;
        @(posedge sys_clk) disable iff (sys_rst) (cs_rise && st_q != S_DONE) |-> !nv_go && !load_go;
    endproperty
    a_short_frame: assert property (p_short_frame) else $error("short frame acted");
    property p_so_off;
        @(posedge sys_clk) disable iff (sys_rst) cs_q |-> !so_oe;
    endproperty
    a_so_off: assert property (p_so_off) else $error("output driven deselected");
    property p_step_up;
        @(posedge sys_clk) disable iff (sys_rst)
            (step_ev && si_q && !load_pend_q && wiper_q[ins_q.psel] != 6'h3F)
            |=> wiper_q[ins_q.psel] == $past(wiper_q[ins_q.psel]) + 6'h01;
    endproperty
    a_step_up: assert property (p_step_up) else $error("step up wrong");
    property p_step_sat;
        @(posedge sys_clk) disable iff (sys_rst)
            (step_ev && !si_q && wiper_q[ins_q.psel] == 6'h00 && !load_pend_q)
            |=> wiper_q[ins_q.psel] == 6'h00;
    endproperty
    a_step_sat: assert property (p_step_sat) else $error("step wrapped");
    property p_bad_id;
        @(posedge sys_clk) disable iff (sys_rst)
            (byte_end && st_q == S_ID && rx_byte[1:0] != {addr_strap_1, addr_strap_0})
            |=> st_q == S_IGN;
    endproperty
    a_bad_id: assert property (p_bad_id) else $error("foreign id accepted");
    property p_status;
        @(posedge sys_clk) disable iff (sys_rst)
            (ins_q == qpd_pkg::INSTR_STATUS && sck_fall && st_q == S_DATA && bit_q != 3'd7)
            |=> !so_o;
    endproperty
    a_status: assert property (p_status) else $error("status upper bits set");
endmodule // qpd_decoder
`default_nettype wire

// ---- verif/qpd_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module qpd_host (
    // clock
    input wire logic sys_clk,
    // serial pins toward the device
    output logic sck,
    output logic si,
    output logic cs_n,
    output logic hold_n,
    input wire logic so_o,
    input wire logic so_oe
);
    // ----------------------------------------
    // bus master model
    // ----------------------------------------
    logic so_last = 1'b0;
    logic so_line;
    // released output shows the inverse of its last value, never a stale copy
    always @(posedge sys_clk) if (so_oe) so_last <= so_o;
    assign so_line = so_oe ? so_o : ~so_last;
    // idle: deselected, clock parked low
    initial begin
        sck = 1'b0;
        si = 1'b0;
        cs_n = 1'b1;
        hold_n = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // 5 low, 3 high: 160 ns; read taken late in the low phase so it has settled
    task automatic xbit(input logic b, output logic r);
        si = b;
        tick(5);
        r = so_line;
        sck = 1'b1;
        tick(3);
        sck = 1'b0;
    endtask
    // id, instruction, then nb data or step bits; pz > 0 pauses after the first one
    task automatic frame(input logic [7:0] id, input logic [7:0] ins, input int nb,
                         input logic [7:0] d, input int pz, output logic [7:0] r);
        logic b;
        r = 8'h00;
        cs_n = 1'b0;
        tick(4);
        for (int i = 7; i >= 0; i--) xbit(id[i], b);
        for (int i = 7; i >= 0; i--) xbit(ins[i], b);
        for (int i = 0; i < nb; i++) begin
            xbit(d[7 - i], b);
            r = {r[6:0], b};
            if (i == 0 && pz > 0) begin
                hold_n = 1'b0;
                tick(pz);
                sck = 1'b1;
                tick(3);
                sck = 1'b0;
                tick(3);
                hold_n = 1'b1;
            end
        end
        tick(4);
        cs_n = 1'b1;
        tick(12);
    endtask
endmodule // qpd_host
`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int NV = 600;
    localparam int LD = 5;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic wp_n = 1'b1;
    logic [1:0] strap = 2'b10;
    logic sck, si, cs_n, hold_n, so_o, so_oe, write_busy;
    logic [23:0] wiper_tap;
    logic [7:0] rd;
    int n_errors = 0;
    int check_count = 0;
    // 50 MHz system clock
    always #10 sys_clk = ~sys_clk;
    qpd_decoder #(.NV_CYC(NV), .LOAD_CYC(LD)) i_qpd_decoder (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .sck(sck), .si(si), .cs_n(cs_n),
        .hold_n(hold_n), .so_o(so_o), .so_oe(so_oe), .addr_strap_0(strap[0]),
        .addr_strap_1(strap[1]), .wp_n(wp_n), .wiper_tap(wiper_tap),
        .write_busy(write_busy));
    qpd_host i_qpd_host (.sys_clk(sys_clk), .sck(sck), .si(si), .cs_n(cs_n),
        .hold_n(hold_n), .so_o(so_o), .so_oe(so_oe));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    function automatic logic [7:0] wip(input int p);
        return {2'b00, wiper_tap[p * 6 +: 6]};
    endfunction
    // frame with a well-formed id for our straps
    task automatic fr(input logic [7:0] ins, input int nb, input logic [7:0] d, input int pz = 0);
        i_qpd_host.frame({qpd_pkg::TYPE_ID, 2'b00, strap}, ins, nb, d, pz, rd);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 2000 && write_busy !== 1'b0; i++) tick(1);
        chk("busy end", {7'h00, write_busy}, 8'h00);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_wiper();
        for (int p = 0; p < 4; p++) begin
            fr({qpd_pkg::OP_WR_WIPER, 2'b00, 2'(p)}, 8, 8'(5 + 13 * p));
            chk("wiper", wip(p), 8'(5 + 13 * p));
            fr({qpd_pkg::OP_RD_WIPER, 2'b00, 2'(p)}, 8, 8'h00);
            chk("rd wiper", rd, 8'(5 + 13 * p));
        end
        chk("so idle", {7'h00, so_oe}, 8'h00);
    endtask
    task automatic t_setting();
        fr({qpd_pkg::OP_WR_SET, 4'b0111}, 8, 8'h15);
        chk("busy", {7'h00, write_busy}, 8'h01);
        fr(qpd_pkg::INSTR_STATUS, 8, 8'h00);
        chk("status busy", rd, 8'h01);
        wait_idle();
        fr(qpd_pkg::INSTR_STATUS, 8, 8'h00);
        chk("status idle", rd, 8'h00);
        fr({qpd_pkg::OP_RD_SET, 4'b0111}, 8, 8'h00);
        chk("rd setting", rd, 8'h15);
    endtask
    task automatic t_copy();
        fr({qpd_pkg::OP_SET2WIP, 4'b0111}, 0, 8'h00);
        tick(10);
        chk("load", wip(3), 8'h15);
        fr({qpd_pkg::OP_WIP2SET, 4'b1000}, 0, 8'h00);
        chk("busy copy", {7'h00, write_busy}, 8'h01);
        wait_idle();
        fr({qpd_pkg::OP_RD_SET, 4'b1000}, 8, 8'h00);
        chk("copy store", rd, 8'h05);
    endtask
    // global store, scramble, global load, then reload by reset
    task automatic t_global();
        fr({qpd_pkg::OP_G_WIP2SET, 4'b0000}, 0, 8'h00);
        wait_idle();
        for (int p = 0; p < 4; p++) fr({qpd_pkg::OP_WR_WIPER, 2'b00, 2'(p)}, 8, 8'h3F);
        fr({qpd_pkg::OP_G_SET2WIP, 4'b0000}, 0, 8'h00);
        tick(10);
        for (int p = 0; p < 4; p++)
            chk("global", wip(p), p == 3 ? 8'h15 : 8'(5 + 13 * p));
        fr({qpd_pkg::OP_WR_WIPER, 4'b0001}, 8, 8'h00);
        sys_rst = 1'b1;
        tick(5);
        sys_rst = 1'b0;
        tick(8);
        chk("reset load", wip(1), 8'h12);
    endtask
    task automatic t_step();
        fr({qpd_pkg::OP_WR_WIPER, 4'b0001}, 8, 8'h3E);
        fr({qpd_pkg::OP_STEP, 4'b0001}, 3, 8'hE0);
        chk("step up", wip(1), 8'h3F);
        fr({qpd_pkg::OP_STEP, 4'b0001}, 2, 8'h00);
        chk("step down", wip(1), 8'h3D);
        fr({qpd_pkg::OP_WR_WIPER, 4'b0001}, 8, 8'h01);
        fr({qpd_pkg::OP_STEP, 4'b0001}, 3, 8'h00);
        chk("step floor", wip(1), 8'h00);
    endtask
    // wrong address, wrong type, short frame, protected store
    task automatic t_refuse();
        i_qpd_host.frame({qpd_pkg::TYPE_ID, 2'b00, ~strap}, 8'hA0, 8, 8'h2A, 0, rd);
        chk("addr miss", wip(0), 8'h05);
        i_qpd_host.frame({~qpd_pkg::TYPE_ID, 2'b00, strap}, 8'hA0, 8, 8'h2A, 0, rd);
        chk("type miss", wip(0), 8'h05);
        fr({qpd_pkg::OP_WR_WIPER, 4'b0000}, 4, 8'h2A);
        chk("short", wip(0), 8'h05);
        wp_n = 1'b0;
        fr({qpd_pkg::OP_WR_SET, 4'b0000}, 8, 8'h2A);
        chk("protect busy", {7'h00, write_busy}, 8'h00);
        wp_n = 1'b1;
        fr({qpd_pkg::OP_RD_SET, 4'b0000}, 8, 8'h00);
        chk("protect keep", rd, 8'h05);
    endtask
    task automatic t_pause();
        fr({qpd_pkg::OP_WR_WIPER, 4'b0010}, 8, 8'h2C, 6);
        chk("pause", wip(2), 8'h2C);
    endtask
    // main sequence
    initial begin
        tick(5);
        sys_rst = 1'b0;
        tick(8);
        chk("reset busy", {7'h00, write_busy}, 8'h00);
        t_wiper();
        t_setting();
        t_copy();
        t_global();
        t_step();
        t_refuse();
        t_pause();
        test_done();
    end
    // watchdog, well beyond the expected run length
    initial begin
        repeat (40000) @(posedge sys_clk);
        n_errors++;
        $display("watchdog expired");
        test_done();
    end
endmodule // tb
`default_nettype wire
